// ### operand_unit_pkg.sv
// constants shared by the second-operand shifter and its write-back control
// assumes a 32-bit instruction word and a 32-bit register file
package operand_unit_pkg;
    // instruction word field positions
    localparam int unsigned IMM_FORM_BIT = 25; // immediate second operand
    localparam int unsigned OPC_HI = 24; // opcode field top
    localparam int unsigned OPC_LO = 21; // opcode field bottom
    localparam int unsigned SET_FLAGS_BIT = 20; // set-flags bit
    localparam int unsigned FIRST_HI = 19; // first operand register field
    localparam int unsigned FIRST_LO = 16;
    localparam int unsigned DEST_HI = 15; // destination register field
    localparam int unsigned DEST_LO = 12;
    localparam int unsigned AMT_REG_HI = 11; // amount register field
    localparam int unsigned AMT_REG_LO = 8;
    localparam int unsigned SHAMT_HI = 11; // five-bit instruction shift amount
    localparam int unsigned SHAMT_LO = 7;
    localparam int unsigned ROT_HI = 11; // immediate rotate field
    localparam int unsigned ROT_LO = 8;
    localparam int unsigned IMM8_HI = 7; // immediate byte
    localparam int unsigned MUST_ZERO_BIT = 7; // zero for register-amount shifts
    localparam int unsigned STYPE_HI = 6; // shift type field
    localparam int unsigned STYPE_LO = 5;
    localparam int unsigned REG_AMT_BIT = 4; // amount from a register
    localparam int unsigned SRC_HI = 3; // operand source register field
    localparam int unsigned CARRY_POS = 29; // carry flag in the status word
    // register numbers and program counter offsets
    localparam logic [3:0] PC_REG_NUM = 4'hF;
    localparam logic [31:0] PC_OFS_IMM = 32'h0000_0008;
    localparam logic [31:0] PC_OFS_REG = 32'h0000_000C;
    // shift type encodings
    localparam logic [1:0] SH_LEFT = 2'h0;
    localparam logic [1:0] SH_RIGHT = 2'h1;
    localparam logic [1:0] SH_ARITH = 2'h2;
    localparam logic [1:0] SH_ROT = 2'h3;
    // opcodes of the flag-only operations
    localparam logic [3:0] OPC_TEST_BITS = 4'h8;
    localparam logic [3:0] OPC_TEST_EQUAL = 4'h9;
    localparam logic [3:0] OPC_COMPARE = 4'hA;
    localparam logic [3:0] OPC_COMPARE_NEG = 4'hB;
    // bus cycle kinds reported per cycle
    localparam logic [1:0] CYC_SEQ = 2'h0;
    localparam logic [1:0] CYC_NONSEQ = 2'h1;
    localparam logic [1:0] CYC_INTERNAL = 2'h2;
    // one-hot sequencing phases
    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_EXEC = 5'h02,
        PH_INTERN = 5'h04,
        PH_NONSEQ = 5'h08,
        PH_REFILL = 5'h10
    } phase_type;
endpackage

// ### imm_rotator.sv
// rotated immediate builder for the second operand
// assumes the caller supplies the immediate byte and rotate field
`timescale 1ns/1ps
module imm_rotator
    import operand_unit_pkg::*;
#(
    parameter int unsigned WIDTH = 32
) (
    input wire logic [7:0] imm_byte_i,
    input wire logic [3:0] rot_field_i,
    input wire logic carry_i,
    output logic [WIDTH-1:0] value_o,
    output logic carry_o
);
    // only the 32-bit word layout is served
    if (WIDTH != 32) begin : g_bad_width
        $error("imm_rotator supports WIDTH 32 only");
    end
    logic [WIDTH-1:0] ext; // zero-extended byte
    logic [2*WIDTH-1:0] dbl; // doubled word, rotate by shifting
    logic [4:0] amt; // twice the rotate field
    // rotate right by twice the field
    always_comb begin
        ext = {{(WIDTH-8){1'b0}}, imm_byte_i};
        amt = {rot_field_i, 1'b0};
        dbl = {ext, ext} >> amt;
        value_o = dbl[WIDTH-1:0];
        // an unrotated byte leaves the carry alone, otherwise the top bit
        carry_o = (rot_field_i == 4'h0) ? carry_i : dbl[WIDTH-1];
    end
endmodule

// ### shift_core.sv
// combinational barrel shifter with carry out
// assumes amounts already chosen by the caller, instruction or register form
`timescale 1ns/1ps
module shift_core
    import operand_unit_pkg::*;
(
    input wire logic [31:0] operand_i,
    input wire logic [1:0] stype_i,
    input wire logic [7:0] amount_i,
    input wire logic from_reg_i,
    input wire logic carry_i,
    output logic [31:0] result_o,
    output logic carry_o
);
    logic [8:0] n; // effective amount, may reach 255
    logic [4:0] k; // low five bits for in-range shifts
    logic extend; // one-position rotate through carry
    logic [32:0] wide; // result with carry slot
    logic [63:0] dbl; // doubled operand for rotates
    // shift selection
    always_comb begin
        n = {1'b0, amount_i};
        extend = 1'b0;
        if (!from_reg_i) begin
            n = {4'h0, amount_i[4:0]};
            // a zero field means 32, except for left shift and rotate
            if (amount_i[4:0] == 5'h00 && stype_i != SH_LEFT) begin
                n = 9'h020;
                extend = (stype_i == SH_ROT);
            end
        end
        k = n[4:0];
        wide = 33'h0;
        dbl = {operand_i, operand_i} >> k;
        result_o = operand_i;
        carry_o = carry_i;
        if (extend) begin
            result_o = {carry_i, operand_i[31:1]};
            carry_o = operand_i[0];
        end else if (n == 9'h000) begin
            result_o = operand_i;
            carry_o = carry_i;
        end else begin
            unique case (stype_i)
                SH_LEFT: begin
                    wide = {1'b0, operand_i} << k;
                    result_o = (n < 9'h020) ? wide[31:0] : 32'h0;
                    carry_o = (n < 9'h020) ? wide[32]
                        : (n == 9'h020) & operand_i[0];
                end
                SH_RIGHT: begin
                    wide = {operand_i, 1'b0} >> k;
                    result_o = (n < 9'h020) ? wide[32:1] : 32'h0;
                    carry_o = (n < 9'h020) ? wide[0]
                        : (n == 9'h020) & operand_i[31];
                end
                SH_ARITH: begin
                    wide = 33'($signed({operand_i, 1'b0}) >>> k);
                    result_o = (n < 9'h020) ? wide[32:1]
                        : {32{operand_i[31]}};
                    carry_o = (n < 9'h020) ? wide[0] : operand_i[31];
                end
                SH_ROT: begin
                    // multiples of 32 leave the word whole, carry is the top bit
                    result_o = dbl[31:0];
                    carry_o = dbl[31];
                end
            endcase
        end
    end
endmodule

// ### operand_unit.sv
// second-operand shifter and write-back control
// assumes a decoder presenting one instruction with its registers
// on issue_i while ready_o is high; results hold until the next issue
`timescale 1ns/1ps
// Operation
// - instruction amount is a five-bit field
// - left shift fills zeros, last out is carry
// - left by zero passes operand, carry kept
// - right immediate zero means 32
// - arithmetic right fills with sign bit
// - arithmetic immediate zero means 32, sign fill
// - rotate reinserts low bits at top
// - rotate immediate zero rotates through carry
// - register amount uses low byte, not counter
// - register amount zero passes operand, carry kept
// - register amounts 1-31 match immediate
// - logical shifts 32 or more give zero
// - arithmetic by 32 or more fills sign
// - rotate by 32 multiples keeps operand
// - register shift needs bit 7 clear
// - immediate byte rotated right by twice field
// - counter destination without flags keeps status
// - counter destination with flags restores status when privileged
// - counter operand reads address plus 8/12
// - compare and test ops write no register
// - legacy test restores status when privileged
// - cycle counts 1S, +1I, 2S+1N
// - logical ops with flags take shifter carry
module operand_unit
    import operand_unit_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic issue_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] instr_addr_i,
    input wire logic [31:0] first_operand_reg_i,
    input wire logic [31:0] operand_source_reg_i,
    input wire logic [31:0] shift_amount_reg_i,
    input wire logic [31:0] current_status_word_i,
    input wire logic [31:0] saved_status_word_i,
    input wire logic privileged_i,
    output logic ready_o,
    output logic [31:0] first_operand_o,
    output logic [31:0] operand2_o,
    output logic shifter_carry_o,
    output logic dest_write_o,
    output logic pc_write_o,
    output logic flags_update_o,
    output logic carry_from_shifter_o,
    output logic status_restore_o,
    output logic [31:0] status_value_o,
    output logic not_data_proc_o,
    output logic amount_reg_fault_o,
    output logic cycle_valid_o,
    output logic [1:0] cycle_kind_o,
    output logic done_o
);
    // all block state
    typedef struct packed {
        phase_type phase; // sequencing phase
        logic reg_amt; // register amount used
        logic pc_wr; // counter written
        logic [31:0] first_op; // first operand as read
        logic [31:0] op2; // second operand
        logic carry; // shifter carry out
        logic dest_wr; // destination written
        logic flags_upd; // flags updated
        logic carry_sh; // carry from shifter
        logic restore; // status word reloaded
        logic [31:0] status; // status word value
        logic not_dp; // not data processing
        logic amt_fault; // counter as amount reg
        logic done; // last busy cycle
    } state_type;

    state_type st_r; // registered state
    state_type st_nxt; // next state

    // decoded fields
    logic imm_form; // immediate second operand
    logic [3:0] opc; // ALU opcode
    logic set_flags; // set-flags bit
    logic [3:0] first_num; // first register
    logic [3:0] dest_num; // destination register
    logic [3:0] src_num; // source register
    logic [3:0] amt_num; // amount register
    logic reg_amt; // amount comes from a register
    logic [1:0] stype; // shift type
    logic flag_only; // compare or test operation
    logic logical_op; // logical class opcode
    logic [31:0] pc_read; // counter as operand
    logic [31:0] first_val; // first operand value
    logic [31:0] src_val; // source operand value
    logic [7:0] amount; // shift amount
    logic carry_in; // current carry flag
    logic [31:0] sh_result; // shifter result
    logic sh_carry; // shifter carry
    logic [31:0] imm_value; // rotated immediate
    logic imm_carry; // immediate carry

    // field extraction
    assign imm_form = instr_i[IMM_FORM_BIT];
    assign opc = instr_i[OPC_HI:OPC_LO];
    assign set_flags = instr_i[SET_FLAGS_BIT];
    assign first_num = instr_i[FIRST_HI:FIRST_LO];
    assign dest_num = instr_i[DEST_HI:DEST_LO];
    assign src_num = instr_i[SRC_HI:0];
    assign amt_num = instr_i[AMT_REG_HI:AMT_REG_LO];
    assign reg_amt = !imm_form && instr_i[REG_AMT_BIT];
    assign stype = instr_i[STYPE_HI:STYPE_LO];
    assign carry_in = current_status_word_i[CARRY_POS];

    // opcode classes
    always_comb begin
        flag_only = opc[3:2] == 2'h2;
        unique case (opc)
            4'h0, 4'h1, OPC_TEST_BITS, OPC_TEST_EQUAL,
            4'hC, 4'hD, 4'hE, 4'hF: logical_op = 1'b1;
            default: logical_op = 1'b0;
        endcase
    end

    // the counter runs ahead by prefetch; one more word when a
    // register amount costs the extra internal cycle
    always_comb begin
        pc_read = instr_addr_i + (reg_amt ? PC_OFS_REG : PC_OFS_IMM);
        first_val = (first_num == PC_REG_NUM) ? pc_read
            : first_operand_reg_i;
        src_val = (src_num == PC_REG_NUM) ? pc_read
            : operand_source_reg_i;
    end

    // amount: register low byte or five-bit field
    always_comb begin
        if (reg_amt) begin
            amount = shift_amount_reg_i[7:0];
        end else begin
            amount = {3'h0, instr_i[SHAMT_HI:SHAMT_LO]};
        end
    end

    // the shifter proper
    shift_core u_shift (
        .operand_i(src_val),
        .stype_i(stype),
        .amount_i(amount),
        .from_reg_i(reg_amt),
        .carry_i(carry_in),
        .result_o(sh_result),
        .carry_o(sh_carry)
    );

    // immediate second operand path
    imm_rotator #(
        .WIDTH(32)
    ) u_imm (
        .imm_byte_i(instr_i[IMM8_HI:0]),
        .rot_field_i(instr_i[ROT_HI:ROT_LO]),
        .carry_i(carry_in),
        .value_o(imm_value),
        .carry_o(imm_carry)
    );

    // next state: capture on issue, then sequence
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        unique case (st_r.phase)
            PH_IDLE: begin
                if (issue_i) begin
                    // second operand: immediate or shifted register
                    if (imm_form) begin
                        st_nxt.op2 = imm_value;
                        st_nxt.carry = imm_carry;
                    end else begin
                        st_nxt.op2 = sh_result;
                        st_nxt.carry = sh_carry;
                    end
                    st_nxt.first_op = first_val;
                    st_nxt.reg_amt = reg_amt;
                    // a set bit 7 with a register amount belongs elsewhere;
                    // so does a compare or test opcode without the set-flags bit
                    st_nxt.not_dp = (reg_amt && instr_i[MUST_ZERO_BIT])
                        || (flag_only && !set_flags);
                    // the counter may not supply a shift amount
                    st_nxt.amt_fault = reg_amt
                        && amt_num == PC_REG_NUM;
                    st_nxt.dest_wr = 1'b0;
                    st_nxt.pc_wr = 1'b0;
                    st_nxt.flags_upd = 1'b0;
                    st_nxt.carry_sh = 1'b0;
                    st_nxt.restore = 1'b0;
                    st_nxt.status = current_status_word_i;
                    if (flag_only) begin
                        // flags only, never a register write
                        st_nxt.flags_upd = set_flags;
                        st_nxt.carry_sh = set_flags && logical_op;
                        // legacy test form names the counter as destination
                        if (opc == OPC_TEST_EQUAL && set_flags
                            && dest_num == PC_REG_NUM) begin
                            st_nxt.flags_upd = 1'b0;
                            st_nxt.carry_sh = 1'b0;
                            st_nxt.restore = privileged_i;
                            if (privileged_i) begin
                                st_nxt.status = saved_status_word_i;
                            end
                        end
                    end else if (dest_num == PC_REG_NUM) begin
                        st_nxt.pc_wr = 1'b1;
                        if (set_flags && privileged_i) begin
                            // user mode has no saved word, so it is left alone
                            st_nxt.restore = 1'b1;
                            st_nxt.status = saved_status_word_i;
                        end
                    end else begin
                        st_nxt.dest_wr = 1'b1;
                        st_nxt.flags_upd = set_flags;
                        st_nxt.carry_sh = set_flags && logical_op;
                        if (set_flags && logical_op) begin
                            // carry slot takes the shifter carry out
                            st_nxt.status[CARRY_POS] = st_nxt.carry;
                        end
                    end
                    // words that are not ours write nothing
                    if (st_nxt.not_dp) begin
                        st_nxt.dest_wr = 1'b0;
                        st_nxt.pc_wr = 1'b0;
                        st_nxt.flags_upd = 1'b0;
                        st_nxt.carry_sh = 1'b0;
                        st_nxt.restore = 1'b0;
                        st_nxt.status = current_status_word_i;
                    end
                    // done marks the last busy cycle, here the first one
                    st_nxt.done = !reg_amt && !st_nxt.pc_wr;
                    st_nxt.phase = PH_EXEC;
                end
            end
            PH_EXEC: begin
                // the one sequential cycle every instruction takes
                if (st_r.reg_amt) begin
                    st_nxt.phase = PH_INTERN;
                    st_nxt.done = !st_r.pc_wr;
                end else if (st_r.pc_wr) begin
                    st_nxt.phase = PH_NONSEQ;
                end else begin
                    st_nxt.phase = PH_IDLE;
                end
            end
            PH_INTERN: begin
                // internal cycle for the amount register
                if (st_r.pc_wr) begin
                    st_nxt.phase = PH_NONSEQ;
                end else begin
                    st_nxt.phase = PH_IDLE;
                end
            end
            PH_NONSEQ: begin
                // fetch from the new counter value
                st_nxt.phase = PH_REFILL;
                st_nxt.done = 1'b1;
            end
            PH_REFILL: begin
                // second sequential cycle refills the pipeline
                st_nxt.phase = PH_IDLE;
            end
            default: begin
                // illegal code drops back to idle
                st_nxt.phase = PH_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.phase <= PH_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // handshake: accept only between sequences
    assign ready_o = st_r.phase == PH_IDLE;

    // cycle kind per busy cycle
    always_comb begin
        cycle_valid_o = !(st_r.phase == PH_IDLE);
        if (st_r.phase == PH_INTERN) begin
            cycle_kind_o = CYC_INTERNAL;
        end else if (st_r.phase == PH_NONSEQ) begin
            cycle_kind_o = CYC_NONSEQ;
        end else begin
            cycle_kind_o = CYC_SEQ;
        end
    end

    // results from the state word
    assign first_operand_o = st_r.first_op;
    assign operand2_o = st_r.op2;
    assign shifter_carry_o = st_r.carry;
    assign dest_write_o = st_r.dest_wr;
    assign pc_write_o = st_r.pc_wr;
    assign flags_update_o = st_r.flags_upd;
    assign carry_from_shifter_o = st_r.carry_sh;
    assign status_restore_o = st_r.restore;
    assign status_value_o = st_r.status;
    assign not_data_proc_o = st_r.not_dp;
    assign amount_reg_fault_o = st_r.amt_fault;
    assign done_o = st_r.done;
endmodule

// ### operand_unit_properties.sv
// port-level assertions on the operand unit, bound to every instance
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module operand_unit_checker
    import operand_unit_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic issue_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] operand_source_reg_i,
    input wire logic [31:0] current_status_word_i,
    input wire logic [31:0] saved_status_word_i,
    input wire logic privileged_i,
    input wire logic ready_o,
    input wire logic [31:0] operand2_o,
    input wire logic shifter_carry_o,
    input wire logic dest_write_o,
    input wire logic pc_write_o,
    input wire logic status_restore_o,
    input wire logic [31:0] status_value_o,
    input wire logic not_data_proc_o,
    input wire logic [1:0] cycle_kind_o,
    input wire logic done_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // decoded terms of the request taken at this edge
    logic take, regamt, pcdst, movop;
    assign take = issue_i && ready_o;
    assign regamt = !instr_i[25] && instr_i[4];
    assign pcdst = instr_i[15:12] == PC_REG_NUM;
    assign movop = instr_i[24:21] == 4'hD;
    property p_busy; take |=> !ready_o; endproperty
    a_busy: assert property (p_busy) else $error("ready after issue");
    property p_plain; take && movop && !regamt && !pcdst |=> done_o; endproperty
    a_plain: assert property (p_plain) else $error("plain not one cycle");
    property p_regamt; take && movop && regamt && !instr_i[7] && !pcdst |=> !done_o ##1 done_o;
    endproperty
    a_regamt: assert property (p_regamt) else $error("reg shift not two cycles");
    property p_pcw; take && movop && !regamt && pcdst |=> cycle_kind_o == CYC_SEQ
        ##1 cycle_kind_o == CYC_NONSEQ ##1 done_o && pc_write_o; endproperty
    a_pcw: assert property (p_pcw) else $error("counter write cycles");
    property p_lsl0; take && movop && !instr_i[25] && instr_i[11:4] == 8'h00
        && instr_i[3:0] != PC_REG_NUM |=> operand2_o == $past(operand_source_reg_i)
        && shifter_carry_o == $past(current_status_word_i[CARRY_POS]); endproperty
    a_lsl0: assert property (p_lsl0) else $error("zero shift altered");
    property p_restore; take && movop && pcdst && instr_i[20] && privileged_i
        |=> status_restore_o && status_value_o == $past(saved_status_word_i); endproperty
    a_restore: assert property (p_restore) else $error("status not restored");
    property p_flagop; take && instr_i[24:23] == 2'h2 && instr_i[20] |=> !dest_write_o;
    endproperty
    a_flagop: assert property (p_flagop) else $error("flag op wrote register");
    property p_nodp; take && regamt && instr_i[7] |=> not_data_proc_o && !dest_write_o
        && !pc_write_o; endproperty
    a_nodp: assert property (p_nodp) else $error("bit7 form accepted");
    c_plain: cover property (take && movop && !pcdst);
    c_restore: cover property (status_restore_o);
    c_nodp: cover property (not_data_proc_o);
endmodule
bind operand_unit operand_unit_checker u_operand_unit_checker (.*);

// ### regfile_model.sv
// register file side of the operand unit, read by instruction fields
// assumes the bench loads regs before each issue
`timescale 1ns/1ps
module regfile_model (
    input wire logic [31:0] instr_i,
    output logic [31:0] first_o,
    output logic [31:0] src_o,
    output logic [31:0] amt_o
);
    logic [31:0] regs [16]; // general registers
    // counter slot gives a changing pattern: the unit must substitute its own
    always_comb begin
        first_o = (instr_i[19:16] == 4'hF) ? ~instr_i : regs[instr_i[19:16]];
        src_o = (instr_i[3:0] == 4'hF) ? ~instr_i : regs[instr_i[3:0]];
        amt_o = regs[instr_i[11:8]];
    end
endmodule

// ### operand_unit_tb_top.sv
// self-checking bench for the operand unit
// assumes design, checker and model are compiled before it
`timescale 1ns/1ps
module operand_unit_tb_top
    import operand_unit_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, iss = 1'b0, pv = 1'b0;
    logic [31:0] ins = 32'h0, cur = 32'h0, sav = 32'hA000_001F, adr = 32'h0000_1000;
    logic [31:0] f_w, s_w, a_w, op2, sval;
    logic rdy, cy, dw, pcw, fu, cfs, rest, ndp, done;
    int err_total = 0, check_count = 0, lat;
    operand_unit u_operand_unit (.clk_sys_i(clk), .rst_i(rst), .issue_i(iss), .instr_i(ins),
        .instr_addr_i(adr), .first_operand_reg_i(f_w), .operand_source_reg_i(s_w),
        .shift_amount_reg_i(a_w), .current_status_word_i(cur), .saved_status_word_i(sav),
        .privileged_i(pv), .ready_o(rdy), .first_operand_o(), .operand2_o(op2),
        .shifter_carry_o(cy), .dest_write_o(dw), .pc_write_o(pcw), .flags_update_o(fu),
        .carry_from_shifter_o(cfs), .status_restore_o(rest), .status_value_o(sval),
        .not_data_proc_o(ndp), .amount_reg_fault_o(), .cycle_valid_o(), .cycle_kind_o(),
        .done_o(done));
    regfile_model u_regfile_model (.instr_i(ins), .first_o(f_w), .src_o(s_w), .amt_o(a_w));
    always #5 clk = ~clk;
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] enc(input logic [3:0] op, input logic s,
        input logic [3:0] rd, input logic [12:0] o2);
        return {4'hE, 2'h0, o2[12], op, s, 4'h0, rd, o2[11:0]};
    endfunction
    function automatic logic [12:0] si(input logic [1:0] t, input logic [4:0] n);
        return {1'b0, n, t, 1'b0, 4'h2};
    endfunction
    function automatic logic [12:0] sr(input logic [1:0] t);
        return {6'h06, t, 5'h12};
    endfunction
    // issue one instruction, then count busy cycles up to done (bounded)
    task automatic run(input logic [31:0] i, src, amt, input logic c, p);
        @(posedge clk);
        u_regfile_model.regs[2] <= src;
        u_regfile_model.regs[3] <= amt;
        ins <= i;
        cur <= {2'h0, c, 29'h0};
        pv <= p;
        iss <= 1'b1;
        @(posedge clk);
        iss <= 1'b0;
        for (lat = 1; lat < 9; lat++) begin
            #1;
            if (done === 1'b1) break;
            @(posedge clk);
        end
    endtask
    task automatic sh(input logic [12:0] o2, input logic [31:0] src, amt, input logic c,
        input logic [31:0] er, input logic ec);
        run(enc(4'hD, 1'b0, 4'h1, o2), src, amt, c, 1'b1);
        chk("operand2", op2, er);
        chk("carry", {31'h0, cy}, {31'h0, ec});
    endtask
    task automatic t_imm_shift;
        sh(si(SH_LEFT, 5'h05), 32'h8C00_0001, 0, 0, 32'h8000_0020, 1);
        sh(si(SH_LEFT, 5'h00), 32'h1234_5678, 0, 1, 32'h1234_5678, 1);
        sh(si(SH_RIGHT, 5'h00), 32'h8000_0001, 0, 0, 32'h0, 1);
        sh(si(SH_RIGHT, 5'h1F), 32'h8000_0000, 0, 1, 32'h1, 0);
        sh(si(SH_ARITH, 5'h04), 32'h8000_0010, 0, 1, 32'hF800_0001, 0);
        sh(si(SH_ARITH, 5'h00), 32'h8000_0001, 0, 0, 32'hFFFF_FFFF, 1);
        sh(si(SH_ROT, 5'h04), 32'h1234_5678, 0, 0, 32'h8123_4567, 1);
        sh(si(SH_ROT, 5'h00), 32'h0000_0003, 0, 1, 32'h8000_0001, 1);
        sh(si(SH_ROT, 5'h00), 32'h0000_0002, 0, 0, 32'h0000_0001, 0);
        chk("plain cycles", lat, 1);
    endtask
    task automatic t_reg_shift;
        sh(sr(SH_RIGHT), 32'h1234_5678, 0, 1, 32'h1234_5678, 1);
        sh(sr(SH_LEFT), 32'h1, 32'hFFFF_FF04, 1, 32'h10, 0);
        sh(sr(SH_RIGHT), 32'h30, 5, 0, 32'h1, 1);
        sh(sr(SH_LEFT), 32'h1, 32, 0, 32'h0, 1);
        sh(sr(SH_LEFT), 32'hFFFF_FFFF, 33, 1, 32'h0, 0);
        sh(sr(SH_RIGHT), 32'h8000_0000, 32, 0, 32'h0, 1);
        sh(sr(SH_RIGHT), 32'hFFFF_FFFF, 40, 1, 32'h0, 0);
        sh(sr(SH_ARITH), 32'h8000_0000, 200, 0, 32'hFFFF_FFFF, 1);
        sh(sr(SH_ROT), 32'h8000_0001, 32, 0, 32'h8000_0001, 1);
        sh(sr(SH_ROT), 32'h1234_5678, 36, 0, 32'h8123_4567, 1);
        chk("reg cycles", lat, 2);
    endtask
    task automatic t_imm_rot;
        sh({1'b1, 4'h4, 8'hFF}, 0, 0, 0, 32'hFF00_0000, 1);
        sh({1'b1, 4'h0, 8'h81}, 0, 0, 0, 32'h81, 0);
        sh({1'b1, 4'hF, 8'h01}, 0, 0, 1, 32'h4, 0);
    endtask
    task automatic t_pc;
        run(enc(4'hD, 1'b0, 4'hF, si(SH_LEFT, 0)), 32'h4000, 0, 0, 1);
        chk("pc write", {31'h0, pcw & ~rest}, 1);
        chk("pc cycles", lat, 3);
        run(enc(4'hD, 1'b1, 4'hF, si(SH_LEFT, 0)), 32'h4000, 0, 0, 1);
        chk("restore", {31'h0, rest}, 1);
        chk("restored", sval, sav);
        run(enc(4'hD, 1'b1, 4'hF, si(SH_LEFT, 0)), 32'h4000, 0, 0, 0);
        chk("user restore", {31'h0, rest}, 0);
        run(enc(4'hD, 1'b0, 4'hF, sr(SH_LEFT)), 32'h4000, 0, 0, 1);
        chk("pc reg cycles", lat, 4);
        run(enc(4'hD, 1'b0, 4'h1, {6'h00, 3'h0, 4'hF}), 0, 0, 0, 1);
        chk("pc imm operand", op2, adr + 8);
        run(enc(4'hD, 1'b0, 4'h1, {6'h06, 2'h0, 5'h1F}), 0, 0, 0, 1);
        chk("pc reg operand", op2, adr + 12);
    endtask
    task automatic t_flag;
        for (int op = 8; op < 12; op++) begin
            run(enc(op[3:0], 1'b1, 4'h1, si(SH_LEFT, 1)), 1, 0, 0, 1);
            chk("flag op write", {30'h0, dw, fu}, 1);
        end
        run(enc(OPC_TEST_EQUAL, 1'b1, 4'hF, si(SH_LEFT, 0)), 0, 0, 0, 1);
        chk("legacy priv", {31'h0, rest}, 1);
        run(enc(OPC_TEST_EQUAL, 1'b1, 4'hF, si(SH_LEFT, 0)), 0, 0, 0, 0);
        chk("legacy user", {31'h0, rest}, 0);
        run(enc(4'hD, 1'b1, 4'h1, {6'h07, 7'h12}), 0, 0, 0, 1);
        chk("bit7 form", {30'h0, ndp, dw}, 2);
        run(enc(4'hD, 1'b1, 4'h1, si(SH_LEFT, 5)), 32'h8C00_0001, 0, 0, 1);
        chk("logic carry", {30'h0, cfs, sval[CARRY_POS]}, 3);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_imm_shift;
        t_reg_shift;
        t_imm_rot;
        t_pc;
        t_flag;
        tally_and_finish;
    end
    // hang guard, far beyond the test length
    initial begin
        #100000;
        err_total++;
        tally_and_finish;
    end
endmodule
